// [hdl/dbio_pkg.sv]
package dbio_pkg;

   // ****************************************************************
   // Bus and window geometry
   // ****************************************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int LINES = 4;
   localparam int RELAYS = 8;
   localparam int IRQ_W = 16;
   localparam logic [5:0] BASE_RESET = 6'h18;
   localparam logic UPPER_HALF_OFF = 1'b0;

   // Register offsets inside the 16-byte window
   localparam logic [3:0] OFS_CODE_LOW = 4'h0;
   localparam logic [3:0] OFS_CODE_HIGH = 4'h1;
   localparam logic [3:0] OFS_RANGE = 4'h2;
   localparam logic [3:0] OFS_RELAY = 4'h3;
   localparam logic [3:0] OFS_LINE_CFG = 4'h4;
   localparam logic [3:0] OFS_LINE_DATA = 4'h5;
   localparam logic [3:0] OFS_ISO_CFG = 4'h6;
   localparam logic [3:0] OFS_OUT_CHAN = 4'h7;
   localparam logic [3:0] OFS_COMMAND = 4'h8;
   localparam logic [3:0] OFS_CONFIG = 4'h9;
   localparam logic [3:0] OFS_QUEUE = 4'ha;
   localparam logic [3:0] OFS_IRQ = 4'hb;
   localparam logic [3:0] OFS_PAGE_12 = 4'hc;
   localparam logic [3:0] OFS_PAGE_13 = 4'hd;
   localparam logic [3:0] OFS_PAGE_14 = 4'he;
   localparam logic [3:0] OFS_PAGE_15 = 4'hf;
   localparam logic [1:0] PAGE_SLOT_15 = 2'h3;
   localparam logic PAGE_COUNTERS = 1'b0;

   // Interrupt levels that may be strapped: 3-7, 9-12, 14, 15
   localparam logic [15:0] IRQ_LEGAL = 16'hdef8;
   localparam logic [15:0] IRQ_ONE = 16'h0001;

   // Source index order in the interrupt register nibbles
   localparam int SRC_TIMER = 3;
   localparam int SRC_LINE = 2;
   localparam int SRC_ISO = 1;
   localparam int SRC_SAMPLE = 0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [5:0] base;
      logic upper_half;
      logic [3:0] offset;
   } dbio_addr_s;

   typedef struct packed {
      logic [2:0] unused;
      logic output_preset;
      logic output_preload;
      logic board_reset;
      logic queue_clear;
      logic sample_trigger;
   } dbio_cmd_s;

   typedef struct packed {
      logic counter_source_sel;
      logic [1:0] unused;
      logic [1:0] counter_rate_sel;
      logic scan_gap_sel;
      logic pacer_gate;
      logic pacer_source;
   } dbio_cfg_s;

   typedef struct packed {
      logic page;
      logic queue_threshold_on;
      logic queue_on;
      logic sequence_on;
   } dbio_queue_s;

   typedef struct packed {
      logic [3:0] flag_wipe;
      logic [3:0] irq_on;
   } dbio_irq_wr_s;

   typedef struct packed {
      logic [3:0] unused;
      logic output_refresh;
      logic [2:0] output_channel_sel;
   } dbio_chan_wr_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic page;
      logic [1:0] slot;
      logic [7:0] wdata;
   } dbio_page_req_s;

   typedef struct packed {
      logic [7:0] fifo_status;
      logic adc_busy;
      logic dac_busy;
      logic [3:0] adc_channel;
   } dbio_core_stat_s;

   typedef struct packed {
      logic prev_iow_n;
      logic prev_ior_n;
      logic [10:0] prev_addr;
      logic [7:0] prev_data;
      logic [5:0] base_strap;
      logic [3:0] irq_sel;
      logic pol_strap;
      logic [7:0] code_low;
      logic [3:0] code_high;
      logic [7:0] range;
      logic [7:0] relay;
      logic [3:0] line_way_out;
      logic [3:0] line_value;
      logic [7:0] iso_cfg;
      logic [2:0] out_chan;
      dbio_cfg_s cfg;
      dbio_queue_s queue;
      logic [3:0] irq_on;
      logic [3:0] pending;
      logic [3:0] line_edge;
      logic [3:0] iso_edge;
      logic [3:0] prev_line;
      logic [3:0] prev_iso;
      logic [7:0] data_out;
      logic data_oe_n;
      logic irq_level;
      logic [15:0] irq_oe_n;
      logic [7:0] relay_pin;
      logic [3:0] line_pin;
      logic [3:0] line_oe_n;
      logic refresh;
      logic range_load;
      logic fifo_pop;
      dbio_cmd_s cmd;
      dbio_page_req_s page_req;
   } dbio_state_s;

endpackage : dbio_pkg

// [hdl/dbio_decode.sv]
// Notes on behaviour
// - Answer sixteen byte addresses, decode low four bits
// - Base from strapped bits 10-5, 32-byte aligned
// - Offsets 12-15 page between counters and calibration
// - Offset 10 bit 3 picks the page
// - Unassigned written bits ignored, no side effect
// - Unassigned read bits return zero
// - Offset 7 write: channel bits 2-0, refresh bit 3
// - Offset 7 read: isolated levels and edge status
// - Offset 5: write line values, read levels, edges
// - Offset 4 read: directions plus status
// - Page zero offset 12 is counter low byte
// - Page zero offset 13 is counter middle byte
// - Page one offset 12 is calibration data
// - Page one offset 13 is calibration address
// - Request driven on one legal strapped level only
// - Requests on input changes and periodic transfers
// - Polarity strap inverts all four isolated inputs
module dbio_decode
   import dbio_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic iow_n_in,
   input wire logic ior_n_in,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n_out,
   input wire logic [5:0] base_strap_in,
   input wire logic [3:0] irq_strap_in,
   input wire logic pol_strap_in,
   input wire logic [LINES-1:0] line_in,
   output logic [LINES-1:0] line_out,
   output logic [LINES-1:0] line_oe_n_out,
   input wire logic [LINES-1:0] opto_in,
   output logic [RELAYS-1:0] relay_pin_out,
   input wire logic [DATA_W-1:0] fifo_data_in,
   output logic fifo_pop_out,
   input wire dbio_core_stat_s core_stat_in,
   input wire logic timer_event_in,
   input wire logic sample_event_in,
   output logic [11:0] output_code_bits_out,
   output logic [2:0] output_channel_sel_out,
   output logic output_refresh_out,
   output logic [7:0] channel_range_out,
   output logic range_load_out,
   output dbio_cmd_s command_out,
   output dbio_cfg_s config_out,
   output dbio_queue_s queue_out,
   output dbio_page_req_s page_req_out,
   input wire logic [DATA_W-1:0] page_rdata_in,
   output logic irq_level_out,
   output logic [IRQ_W-1:0] irq_oe_n_out
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Window hit: strapped base on bits 10-5, bit 4 clear
   function automatic logic dbio_hit(input logic [10:0] a, input logic [5:0] base);
      dbio_addr_s f;
      f = dbio_addr_s'(a);
      return (f.base == base) && (f.upper_half == UPPER_HALF_OFF);
   endfunction : dbio_hit

   function automatic logic [3:0] dbio_offset(input logic [10:0] a);
      dbio_addr_s f;
      f = dbio_addr_s'(a);
      return f.offset;
   endfunction : dbio_offset

   // Live line level: outputs read back the programmed value
   function automatic logic [3:0] dbio_levels(input logic [3:0] way, input logic [3:0] val,
                                              input logic [3:0] pins);
      return (way & val) | (~way & pins);
   endfunction : dbio_levels

   // ****************************************************************
   // State
   // ****************************************************************
   dbio_state_s s;
   dbio_state_s next_s;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // Working terms for one cycle
   logic hit_now;
   logic wr_take;
   logic rd_done;
   logic [3:0] wr_ofs;
   logic [3:0] rd_ofs;
   logic [3:0] iso_now;
   logic [3:0] iso_rise;
   logic [3:0] iso_fall;
   logic [3:0] iso_hit;
   logic [3:0] line_chg;
   logic [3:0] wipe;
   logic [3:0] src_set;

   logic [7:0] rd_val;

   dbio_irq_wr_s irq_wr;
   dbio_chan_wr_s chan_wr;
   dbio_cmd_s cmd_wr;

   always_comb begin
      next_s = s;
      // Bus and straps sampled every cycle
      next_s.prev_iow_n = iow_n_in;
      next_s.prev_ior_n = ior_n_in;
      next_s.prev_addr = addr_in;
      next_s.prev_data = data_in;
      next_s.base_strap = base_strap_in;
      next_s.irq_sel = irq_strap_in;
      next_s.pol_strap = pol_strap_in;

      // Pulses live for a single cycle
      next_s.refresh = 1'b0;
      next_s.range_load = 1'b0;
      next_s.fifo_pop = 1'b0;
      next_s.cmd = '0;
      next_s.page_req.wr = 1'b0;
      next_s.page_req.rd = 1'b0;

      // Writes land at the end of the strobe, using the address and data held a cycle back
      hit_now = dbio_hit(addr_in, s.base_strap);
      wr_take = !s.prev_iow_n && iow_n_in && dbio_hit(s.prev_addr, s.base_strap);
      rd_done = !s.prev_ior_n && ior_n_in && dbio_hit(s.prev_addr, s.base_strap);

      // Captured byte fields
      wr_ofs = dbio_offset(s.prev_addr);
      rd_ofs = dbio_offset(addr_in);
      irq_wr = dbio_irq_wr_s'(s.prev_data);
      chan_wr = dbio_chan_wr_s'(s.prev_data);
      cmd_wr = dbio_cmd_s'(s.prev_data);

      // Isolated inputs, optionally inverted by strap
      iso_now = opto_in ^ {LINES{s.pol_strap}};
      iso_rise = iso_now & ~s.prev_iso;
      iso_fall = ~iso_now & s.prev_iso;
      iso_hit = s.iso_cfg[7:4] & ((s.iso_cfg[3:0] & iso_rise) | (~s.iso_cfg[3:0] & iso_fall));
      next_s.prev_iso = iso_now;

      // Any change on a digital line counts as an edge
      line_chg = line_in ^ s.prev_line;
      next_s.prev_line = line_in;

      // Interrupt sources
      src_set = '0;
      src_set[SRC_TIMER] = timer_event_in;
      src_set[SRC_LINE] = |line_chg;
      src_set[SRC_ISO] = |iso_hit;
      src_set[SRC_SAMPLE] = sample_event_in;

      // Only writes wipe flags
      wipe = '0;

      // Register writes; bits with no function are dropped by field selection
      if (wr_take) begin
         unique case (wr_ofs)
            OFS_CODE_LOW: begin
               next_s.code_low = s.prev_data;
            end
            OFS_CODE_HIGH: begin
               next_s.code_high = s.prev_data[3:0];
            end
            OFS_RANGE: begin
               next_s.range = s.prev_data;
               next_s.range_load = 1'b1;
            end
            OFS_RELAY: begin
               next_s.relay = s.prev_data;
            end
            OFS_LINE_CFG: begin
               next_s.line_way_out = s.prev_data[3:0];
            end
            OFS_LINE_DATA: begin
               // Lines in input mode keep their old value
               next_s.line_value = (s.line_way_out & s.prev_data[3:0])
                                 | (~s.line_way_out & s.line_value);
            end
            OFS_ISO_CFG: begin
               next_s.iso_cfg = s.prev_data;
            end
            OFS_OUT_CHAN: begin
               next_s.out_chan = chan_wr.output_channel_sel;
               next_s.refresh = chan_wr.output_refresh;
            end
            OFS_COMMAND: begin
               // Pulses, not stored
               next_s.cmd = cmd_wr;
               next_s.cmd.unused = '0;
            end
            OFS_CONFIG: begin
               next_s.cfg = dbio_cfg_s'(s.prev_data);
               next_s.cfg.unused = '0;
            end
            OFS_QUEUE: begin
               next_s.queue = dbio_queue_s'(s.prev_data[3:0]);
            end
            OFS_IRQ: begin
               wipe = irq_wr.flag_wipe;
               next_s.irq_on = irq_wr.irq_on;
            end
            OFS_PAGE_12, OFS_PAGE_13, OFS_PAGE_14, OFS_PAGE_15: begin
               // Passed to counter or calibration engine per page
               next_s.page_req.wr = 1'b1;
               next_s.page_req.page = s.queue.page;
               next_s.page_req.slot = wr_ofs[1:0];
               next_s.page_req.wdata = s.prev_data;
            end
         endcase
      end

      // A set in the same cycle as its wipe wins
      next_s.pending = (s.pending & ~wipe) | src_set;

      // Read side effects take place when the strobe ends
      if (rd_done) begin
         unique case (dbio_offset(s.prev_addr))
            OFS_CODE_LOW, OFS_CODE_HIGH: begin
               // Host must pair low and high bytes
               next_s.fifo_pop = 1'b1;
            end
            OFS_LINE_DATA: begin
               next_s.line_edge = '0;
            end
            OFS_OUT_CHAN: begin
               next_s.iso_edge = '0;
            end
            OFS_PAGE_12, OFS_PAGE_13, OFS_PAGE_14, OFS_PAGE_15: begin
               next_s.page_req.rd = 1'b1;
            end
            default: begin
               next_s.page_req.rd = 1'b0;
            end
         endcase
      end

      // Edge flags set after the clear so a fresh edge survives the read
      next_s.line_edge = next_s.line_edge | line_chg;
      next_s.iso_edge = next_s.iso_edge | iso_hit;

      // Paged engine sees the current slot while a read is under way
      if (!ior_n_in && hit_now) begin
         next_s.page_req.page = s.queue.page;
         next_s.page_req.slot = rd_ofs[1:0];
      end

      // Read data mux; every unassigned bit is zero
      rd_val = '0;
      unique case (rd_ofs)
         OFS_CODE_LOW, OFS_CODE_HIGH: begin
            rd_val = fifo_data_in;
         end
         OFS_RANGE: begin
            rd_val = s.range;
         end
         OFS_RELAY: begin
            rd_val = s.relay;
         end
         OFS_LINE_CFG: begin
            // Direction with the line status alongside
            rd_val = {s.line_edge, s.line_way_out};
         end
         OFS_LINE_DATA: begin
            rd_val = {s.line_edge, dbio_levels(s.line_way_out, s.line_value, line_in)};
         end
         OFS_ISO_CFG: begin
            rd_val = s.iso_cfg;
         end
         OFS_OUT_CHAN: begin
            rd_val = {s.iso_edge, iso_now};
         end
         OFS_COMMAND: begin
            rd_val = {3'h0, s.pol_strap, core_stat_in.adc_channel};
         end
         OFS_CONFIG: begin
            rd_val = {core_stat_in.adc_busy, core_stat_in.dac_busy, s.cfg.counter_source_sel,
                      s.cfg.counter_rate_sel, s.cfg.scan_gap_sel, s.cfg.pacer_gate,
                      s.cfg.pacer_source};
         end
         OFS_QUEUE: begin
            // Queue flags of the core on top
            rd_val = {core_stat_in.fifo_status[7:4], s.queue};
         end
         OFS_IRQ: begin
            // Flags above enables
            rd_val = {s.pending, s.irq_on};
         end
         OFS_PAGE_12, OFS_PAGE_13, OFS_PAGE_14, OFS_PAGE_15: begin
            // Counter page has nothing to read at its last slot
            if (s.queue.page == PAGE_COUNTERS && rd_ofs[1:0] == PAGE_SLOT_15) begin
               rd_val = '0;
            end else begin
               rd_val = page_rdata_in;
            end
         end
      endcase

      // Data bus is driven only while a read hits the window
      if (!ior_n_in && hit_now) begin
         next_s.data_out = rd_val;
         next_s.data_oe_n = 1'b0;
      end else begin
         next_s.data_out = '0;
         next_s.data_oe_n = 1'b1;
      end

      // One request line, and only if the strap names a legal level
      next_s.irq_level = |(s.pending & s.irq_on);
      next_s.irq_oe_n = ~(IRQ_LEGAL & (IRQ_ONE << s.irq_sel));

      // Pins: relays are inverted so reset leaves them off
      next_s.relay_pin = ~next_s.relay;
      next_s.line_pin = next_s.line_value;
      next_s.line_oe_n = ~next_s.line_way_out;
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Reset puts relays off, lines to input and the bus released
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s <= '0;
         s.prev_iow_n <= 1'b1;
         s.prev_ior_n <= 1'b1;
         s.base_strap <= BASE_RESET;
         s.data_oe_n <= 1'b1;
         s.irq_oe_n <= '1;
         s.relay_pin <= '1;
         s.line_oe_n <= '1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs, all straight from state
   // ****************************************************************
   assign data_out = s.data_out;
   assign data_oe_n_out = s.data_oe_n;

   assign line_out = s.line_pin;
   assign line_oe_n_out = s.line_oe_n;
   assign relay_pin_out = s.relay_pin;

   assign fifo_pop_out = s.fifo_pop;

   assign output_code_bits_out = {s.code_high, s.code_low};
   assign output_channel_sel_out = s.out_chan;
   assign output_refresh_out = s.refresh;
   assign channel_range_out = s.range;
   assign range_load_out = s.range_load;

   assign command_out = s.cmd;
   assign config_out = s.cfg;
   assign queue_out = s.queue;
   assign page_req_out = s.page_req;

   assign irq_level_out = s.irq_level;
   assign irq_oe_n_out = s.irq_oe_n;

endmodule : dbio_decode

// [testbench/dbio_decode_props.sv]
module dbio_decode_props
   import dbio_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic iow_n_in,
   input wire logic ior_n_in,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic data_oe_n_out,
   input wire logic [5:0] base_strap_in,
   input wire logic [3:0] irq_strap_in,
   input wire logic [LINES-1:0] line_oe_n_out,
   input wire logic [RELAYS-1:0] relay_pin_out,
   input wire logic [2:0] output_channel_sel_out,
   input wire logic output_refresh_out,
   input wire dbio_cmd_s command_out,
   input wire logic irq_level_out,
   input wire logic [IRQ_W-1:0] irq_oe_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // Write capture, mirrors the strobe-release taking of a write
   // ****************************************************************
   default clocking dc @(posedge clock_in);
   endclocking
   default disable iff (!reset_n_in);
   logic q_iow;
   logic [10:0] q_addr;
   logic [7:0] q_data;
   logic [1:0] up_cnt;
   logic wr_take;
   // Previous bus values; up_cnt hides the strap load after reset
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q_iow <= 1'b1;
         q_addr <= '0;
         q_data <= '0;
         up_cnt <= '0;
      end else begin
         q_iow <= iow_n_in;
         q_addr <= addr_in;
         q_data <= data_in;
         if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
         end
      end
   end
   assign wr_take = iow_n_in && !q_iow && (q_addr[10:4] == {base_strap_in, 1'b0});
   // ****************************************************************
   // Properties
   // ****************************************************************
   a_read_drive: assert property ((!ior_n_in && addr_in[10:4] == {base_strap_in, 1'b0}) |=> !data_oe_n_out)
      else $error("read hit did not drive the data bus");
   a_miss_silent: assert property ((!ior_n_in && addr_in[4]) |=> data_oe_n_out)
      else $error("upper half of the aligned block was answered");
   a_read_release: assert property (ior_n_in ##1 ior_n_in |=> data_oe_n_out)
      else $error("data bus still driven after read ended");
   a_relay_write: assert property ((wr_take && q_addr[3:0] == 4'h3) |=> relay_pin_out == ~$past(q_data))
      else $error("relay pins not inverse of written value");
   a_refresh_pulse: assert property ((wr_take && q_addr[3:0] == 4'h7)
      |=> output_refresh_out == $past(q_data[3]) && output_channel_sel_out == $past(q_data[2:0]))
      else $error("channel write did not give channel and refresh");
   a_refresh_once: assert property (output_refresh_out |=> !output_refresh_out)
      else $error("refresh pulse longer than one cycle");
   a_cmd_value: assert property ((wr_take && q_addr[3:0] == 4'h8) |=> command_out == {3'h0, $past(q_data[4:0])})
      else $error("command pulses differ from written bits");
   a_irq_strap: assert property ((up_cnt == 2'h3 && $stable(irq_strap_in)) |-> irq_oe_n_out ==
      (IRQ_LEGAL[irq_strap_in] ? ~(IRQ_ONE << irq_strap_in) : 16'hffff))
      else $error("request line enables do not match strap");
   a_line_drive: assert property ((wr_take && q_addr[3:0] == 4'h4) |=> line_oe_n_out == ~$past(q_data[3:0]))
      else $error("line direction not taken from write");
   a_irq_mask: assert property ((wr_take && q_addr[3:0] == 4'hb && q_data[3:0] == 4'h0) |=> ##1 (!irq_level_out)[*2])
      else $error("request raised with every source disabled");
   c_paged_read: cover property (!ior_n_in && addr_in[3:2] == 2'h3);
   c_refresh: cover property (output_refresh_out);
   c_irq: cover property (irq_level_out);
endmodule : dbio_decode_props

bind dbio_decode dbio_decode_props u_dbio_decode_props (.clock_in(clock_in),
   .reset_n_in(reset_n_in), .addr_in(addr_in), .iow_n_in(iow_n_in), .ior_n_in(ior_n_in),
   .data_in(data_in), .data_oe_n_out(data_oe_n_out), .base_strap_in(base_strap_in),
   .irq_strap_in(irq_strap_in), .line_oe_n_out(line_oe_n_out), .relay_pin_out(relay_pin_out),
   .output_channel_sel_out(output_channel_sel_out), .output_refresh_out(output_refresh_out),
   .command_out(command_out), .irq_level_out(irq_level_out), .irq_oe_n_out(irq_oe_n_out));

// [testbench/dbio_host.sv]
module dbio_host (
   input wire logic clock_in,
   input wire logic [7:0] rdata_in,
   input wire logic oe_n_in,
   output logic [10:0] addr_out,
   output logic iow_n_out,
   output logic ior_n_out,
   output logic [7:0] wdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // Host cycles, changed on falling edges only
   // ****************************************************************
   initial begin
      addr_out = '0;
      iow_n_out = 1'b1;
      ior_n_out = 1'b1;
      wdata_out = '0;
   end
   // Released bus shows inverted values so a stale hold cannot pass
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clock_in);
      addr_out = a;
      wdata_out = d;
      iow_n_out = 1'b0;
      @(negedge clock_in);
      iow_n_out = 1'b1;
      @(negedge clock_in);
      addr_out = ~a;
      wdata_out = ~d;
      @(negedge clock_in);
   endtask : wr
   // Strobe held three cycles, covering the two-cycle paged answer
   task automatic rd(input logic [10:0] a, output logic [7:0] q, output logic o);
      @(negedge clock_in);
      addr_out = a;
      ior_n_out = 1'b0;
      repeat (3) @(negedge clock_in);
      q = rdata_in;
      o = oe_n_in;
      ior_n_out = 1'b1;
      @(negedge clock_in);
      addr_out = ~a;
      @(negedge clock_in);
   endtask : rd
endmodule : dbio_host

// [testbench/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dbio_pkg::*;
   logic clk = 1'b0;
   logic rst_n, iow_n, ior_n, oe_n, pol, tev, sev, refresh, range_load, pop, irq_level;
   logic [10:0] addr;
   logic [5:0] base = 6'h1a;
   logic [7:0] wdata, rdata, relay_pin, range, prd;
   logic [3:0] irq_strap, ext, line_out, line_oe_n, line_w, opto;
   logic [11:0] code;
   logic [2:0] chan_sel;
   logic [15:0] irq_oe_n;
   dbio_cmd_s cmd;
   dbio_cfg_s cfg;
   dbio_queue_s queue;
   dbio_page_req_s preq;
   dbio_core_stat_s stat;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_pulse = 0;
   always #12.5 clk = ~clk;
   // Pulse tally
   always @(negedge clk) n_pulse += pop + range_load;
   // Wire level of each line from both drivers; engine data marks page and slot
   assign line_w = (~line_oe_n & line_out) | (line_oe_n & ext);
   assign prd = {3'h5, preq.page, 2'h0, preq.slot};
   dbio_decode u_dbio_decode (.clock_in(clk), .reset_n_in(rst_n), .addr_in(addr),
      .iow_n_in(iow_n), .ior_n_in(ior_n), .data_in(wdata), .data_out(rdata),
      .data_oe_n_out(oe_n), .base_strap_in(base), .irq_strap_in(irq_strap),
      .pol_strap_in(pol), .line_in(line_w), .line_out(line_out), .line_oe_n_out(line_oe_n),
      .opto_in(opto), .relay_pin_out(relay_pin), .fifo_data_in(8'h6c), .fifo_pop_out(pop),
      .core_stat_in(stat), .timer_event_in(tev), .sample_event_in(sev),
      .output_code_bits_out(code), .output_channel_sel_out(chan_sel),
      .output_refresh_out(refresh), .channel_range_out(range), .range_load_out(range_load),
      .command_out(cmd), .config_out(cfg), .queue_out(queue), .page_req_out(preq),
      .page_rdata_in(prd), .irq_level_out(irq_level), .irq_oe_n_out(irq_oe_n));
   dbio_host u_dbio_host (.clock_in(clk), .rdata_in(rdata), .oe_n_in(oe_n), .addr_out(addr),
      .iow_n_out(iow_n), .ior_n_out(ior_n), .wdata_out(wdata));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [10:0] ad(input logic [3:0] ofs);
      return {base, 1'b0, ofs};
   endfunction : ad
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
      u_dbio_host.wr(ad(ofs), d);
   endtask : wr
   // Bit 8 of the compare is the bus enable, which must be low
   task automatic rdc(input logic [3:0] ofs, input logic [7:0] e);
      logic [7:0] q;
      logic o;
      u_dbio_host.rd(ad(ofs), q, o);
      chk({7'h0, o, q}, {8'h00, e});
   endtask : rdc
   task automatic end_sim;
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   // Hang guard well above the length of the sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      logic [7:0] q;
      logic o;
      rst_n = 1'b0;
      {pol, tev, sev} = 3'b000;
      irq_strap = 4'h5;
      ext = 4'h0;
      opto = 4'h5;
      stat = {8'h30, 2'b00, 4'h9};
      // Each strap pair gets a fresh reset; straps are sampled every cycle
      for (int k = 0; k < 2; k++) begin
         pol = k[0];
         irq_strap = k[0] ? 4'h8 : 4'h5;
         rst_n = 1'b0;
         repeat (5) @(negedge clk);
         chk({relay_pin, 4'h0, line_oe_n}, 16'hff0f);
         rst_n = 1'b1;
         repeat (2) @(negedge clk);
         chk(irq_oe_n, k[0] ? 16'hffff : 16'hffdf);
         rdc(OFS_OUT_CHAN, k[0] ? 8'h0a : 8'h05);
         rdc(OFS_COMMAND, {3'h0, k[0], 4'h9});
      end
      wr(OFS_RELAY, 8'ha5);
      u_dbio_host.wr({base, 1'b1, OFS_RELAY}, 8'hff);
      rdc(OFS_RELAY, 8'ha5);
      chk({8'h00, relay_pin}, 16'h005a);
      u_dbio_host.rd({base, 1'b1, OFS_RELAY}, q, o);
      chk({15'h0, o}, 16'h0001);
      wr(OFS_CODE_HIGH, 8'hff);
      wr(OFS_CODE_LOW, 8'h12);
      chk({4'h0, code}, 16'h0f12);
      wr(OFS_CONFIG, 8'hff);
      rdc(OFS_CONFIG, 8'h3f);
      wr(OFS_OUT_CHAN, 8'hfd);
      chk({13'h0, chan_sel}, 16'h0005);
      wr(OFS_COMMAND, 8'hff);
      wr(OFS_RANGE, 8'h3c);
      rdc(OFS_RANGE, 8'h3c);
      chk({cfg, range}, 16'h9f3c);
      rdc(OFS_CODE_LOW, 8'h6c);
      chk(n_pulse[15:0], 16'h0002);
      wr(OFS_QUEUE, 8'h0f);
      rdc(OFS_QUEUE, 8'h3f);
      chk({12'h0, queue}, 16'h000f);
      rdc(OFS_PAGE_12, 8'hb0);
      rdc(OFS_PAGE_13, 8'hb1);
      wr(OFS_QUEUE, 8'hf0);
      rdc(OFS_QUEUE, 8'h30);
      rdc(OFS_PAGE_12, 8'ha0);
      rdc(OFS_PAGE_13, 8'ha1);
      rdc(OFS_PAGE_15, 8'h00);
      // Isolated edge on line 0, rising of the inverted level
      wr(OFS_ISO_CFG, 8'h11);
      rdc(OFS_ISO_CFG, 8'h11);
      wr(OFS_IRQ, 8'h0b);
      opto = 4'h4;
      tev = 1'b1;
      sev = 1'b1;
      @(negedge clk);
      {tev, sev} = 2'b00;
      repeat (3) @(negedge clk);
      chk({15'h0, irq_level}, 16'h0001);
      rdc(OFS_OUT_CHAN, 8'h1b);
      rdc(OFS_IRQ, 8'hbb);
      wr(OFS_IRQ, 8'hf0);
      rdc(OFS_IRQ, 8'h00);
      chk({15'h0, irq_level}, 16'h0000);
      // Lines 1..0 out, 3..2 in; driving outputs makes edges too
      wr(OFS_LINE_CFG, 8'h03);
      wr(OFS_LINE_DATA, 8'hff);
      chk({12'h0, line_out}, 16'h0003);
      rdc(OFS_LINE_DATA, 8'h33);
      rdc(OFS_LINE_CFG, 8'h03);
      ext = 4'h8;
      repeat (2) @(negedge clk);
      rdc(OFS_LINE_CFG, 8'h83);
      rdc(OFS_LINE_DATA, 8'h8b);
      end_sim();
   end
endmodule : testbench
